// File: dv/lmb_mcu_model.sv
// microcontroller bus model, one access per task call
// assumes registered answers and strobes held until they come
`timescale 1ns/10ps
module lmb_mcu_model (
    input wire logic clk_in,
    input wire logic sep_in,
    input wire logic mux_in,
    input wire logic rd_oe_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] ad_out,
    output logic [7:0] addr_out,
    output logic ale_out,
    output logic wctl_out,
    output logic rds_out
);
    initial begin
        ad_out = 8'h00;
        addr_out = 8'h00;
        ale_out = 1'b0;
        wctl_out = 1'b1;
        rds_out = 1'b0;
    end
    // idle strobe level: high for separate strobes, low for a data strobe
    task automatic park();
        @(posedge clk_in);
        rds_out <= sep_in;
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q = 8'h00;
        @(posedge clk_in);
        addr_out <= a;
        ad_out <= mux_in ? a : d;
        ale_out <= mux_in;
        if (mux_in) begin
            @(posedge clk_in);
            ale_out <= 1'b0;
            ad_out <= d;
        end
        // strobe, direction and data held to the answer
        wctl_out <= ~wr;
        rds_out <= sep_in ? wr : 1'b1;
        for (n = 0; n < 12; n++) begin
            @(posedge clk_in);
            if (!wr && rd_oe_in && !ok) begin
                ok = 1'b1;
                q = rdata_in;
            end
            if (n >= 2 && (wr || ok)) break;
        end
        wctl_out <= 1'b1;
        rds_out <= sep_in;
        // released bus shows the inverse so stale data cannot pass
        ad_out <= ~ad_out;
        repeat (3) @(posedge clk_in);
    endtask
endmodule

// File: dv/lmb_port_sva.sv
// checker for the local microcontroller port
// assumes it is bound to lmb_mcu_port and sees only its ports
`timescale 1ns/10ps
module lmb_port_sva (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic write_ctl_in,
    input wire logic read_or_data_strobe_in,
    input wire logic ad_oe_out,
    input wire logic irq_out,
    input wire logic irq_oe_out,
    input wire logic buf_req_out,
    input wire lmb_pkg::lmb_buf_cmd_t buf_cmd_out,
    input wire logic buf_ack_in,
    input wire logic xfer_busy_in,
    input wire logic pcr_sel_out,
    input wire logic muxed_mode_out,
    input wire logic strobe_style_out,
    input wire logic host_type_out
);
    logic rd_act;
    logic [1:0] cyc;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    // read strobe active in either style
    assign rd_act = strobe_style_out ? !read_or_data_strobe_in
        : (read_or_data_strobe_in && write_ctl_in);
    // counts edges after release; straps settle by the third
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            cyc <= 2'h0;
        end else if (cyc != 2'h3) begin
            cyc <= cyc + 2'h1;
        end
    end
    a_oe_needs_strobe: assert property (
        $rose(ad_oe_out) |-> $past(rd_act)) else $error("bus driven without read strobe");
    a_oe_drops_late: assert property (
        !rd_act |-> ##2 !ad_oe_out) else $error("bus still driven after strobe end");
    a_req_holds_cmd: assert property (
        buf_req_out && !buf_ack_in |=> buf_req_out && $stable(buf_cmd_out))
        else $error("buffer request changed before grant");
    a_req_ends_ack: assert property (
        buf_req_out && buf_ack_in |=> !buf_req_out) else $error("buffer request kept after grant");
    a_direct_when_idle: assert property (
        $rose(buf_req_out) && buf_cmd_out.direct |-> !$past(xfer_busy_in))
        else $error("direct buffer access during transfer");
    a_pcr_one_pulse: assert property (
        pcr_sel_out |=> !pcr_sel_out) else $error("register file select too long");
    a_irq_drive_kind: assert property (
        irq_out |-> irq_oe_out) else $error("interrupt level without enable");
    a_straps_held: assert property (
        cyc == 2'h3 |-> $stable({muxed_mode_out, strobe_style_out, host_type_out}))
        else $error("strap latch changed");
    c_read: cover property ($rose(ad_oe_out));
    c_grant: cover property (buf_req_out && buf_ack_in);
    c_irq: cover property ($rose(irq_oe_out));
endmodule

bind lmb_mcu_port lmb_port_sva i_lmb_port_sva (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .write_ctl_in(write_ctl_in), .read_or_data_strobe_in(read_or_data_strobe_in),
    .ad_oe_out(ad_oe_out), .irq_out(irq_out), .irq_oe_out(irq_oe_out),
    .buf_req_out(buf_req_out), .buf_cmd_out(buf_cmd_out), .buf_ack_in(buf_ack_in),
    .xfer_busy_in(xfer_busy_in), .pcr_sel_out(pcr_sel_out), .muxed_mode_out(muxed_mode_out),
    .strobe_style_out(strobe_style_out), .host_type_out(host_type_out));

// File: dv/tb.sv
// self-checking bench for the local microcontroller port
// assumes the bus model beside it and a buffer manager stub here
`timescale 1ns/10ps
module tb;
    import lmb_pkg::*;
    logic clk = 1'b0, srst = 1'b1, sep = 1'b0, mux = 1'b1, ack = 1'b0, busy = 1'b0;
    logic ale, wctl, rds, oe, irq, irq_oe, req, psel, ok, mux_m, sty_m, host_m;
    logic [7:0] ad, addr, rd, q, bd = 8'h00, brd = 8'h00, prd = 8'h00;
    logic [11:0] evt = 12'h000;
    logic [15:0] seed = 16'h3274, p;
    logic [1:0] stall = 2'h0;
    lmb_buf_cmd_t cmd, lcmd;
    lmb_pcr_cmd_t pcmd, lp;
    int n_mismatch = 0, num_checks = 0, nreq = 0, npsel = 0, n0, i;
    always #2 clk = ~clk;
    lmb_mcu_port i_lmb_mcu_port (.ref_clk_in(clk), .srst_in(srst), .ad_in(ad), .ad_out(rd),
        .ad_oe_out(oe), .addr_in(addr), .ale_in(ale), .write_ctl_in(wctl),
        .read_or_data_strobe_in(rds), .bd_in(bd), .irq_evt_in(evt), .irq_out(irq),
        .irq_oe_out(irq_oe), .buf_req_out(req), .buf_cmd_out(cmd), .buf_ack_in(ack),
        .buf_rdata_in(brd), .xfer_busy_in(busy), .pcr_sel_out(psel), .pcr_cmd_out(pcmd),
        .pcr_rdata_in(prd), .muxed_mode_out(mux_m), .strobe_style_out(sty_m),
        .host_type_out(host_m));
    lmb_mcu_model i_lmb_mcu_model (.clk_in(clk), .sep_in(sep), .mux_in(mux), .rd_oe_in(oe),
        .rdata_in(rd), .ad_out(ad), .addr_out(addr), .ale_out(ale), .wctl_out(wctl),
        .rds_out(rds));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // buffer manager stub grants after a random stall
    always @(posedge clk) begin
        ack <= 1'b0;
        if (req && !ack && stall != 2'h0) begin
            stall <= stall - 2'h1;
        end else if (req && !ack) begin
            ack <= 1'b1;
            brd <= cmd.addr[7:0] ^ 8'hA5;
            lcmd <= cmd;
            nreq <= nreq + 1;
            stall <= seed[1:0];
        end
        if (psel) begin
            npsel <= npsel + 1;
            lp <= pcmd;
        end
    end
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        chk16({8'h00, g}, {8'h00, e});
    endtask
    task automatic chk_b(input logic g, input logic e);
        chk16({15'h0000, g}, {15'h0000, e});
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        i_lmb_mcu_model.acc(w, a, d, q, ok);
        // buffer writes are granted after the strobe ends; next strobe would be lost
        while (req) begin
            @(posedge clk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        i_lmb_mcu_model.acc(1'b0, a, 8'h00, q, ok);
        chk8(q, e);
    endtask
    task automatic rst(input logic [7:0] b);
        srst <= 1'b1;
        bd <= b;
        sep <= b[6];
        mux <= b[7];
        repeat (3) @(posedge clk);
        i_lmb_mcu_model.park();
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        // straps move after release; latched modes must not
        bd <= ~b;
        repeat (2) @(posedge clk);
        chk_b(mux_m, b[7]);
        chk_b(sty_m, b[6]);
        chk_b(host_m, b[5]);
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        rst(8'h80);
        wr(A_CTRL, 8'h01);
        rdc(A_CTRL, 8'h01);
        rst(8'h60);
        rdc(A_CTRL, 8'h00);
        rdc(8'h3F, 8'h00);
        chk_b(ok, 1'b0);
        prd <= seed[7:0];
        wr(8'h61, 8'h5A);
        rdc(8'h63, 8'h00);
        chk16(16'(npsel), 16'h0000);
        wr(A_BASE, 8'h01);
        rdc(8'h63, prd);
        chk16({13'h0000, lp.addr}, 16'h0003);
        rdc(8'h43, 8'h00);
        chk16(16'(npsel), 16'h0001);
        wr(8'h65, 8'hA7);
        chk16({12'h000, lp.wr, lp.addr}, 16'h000D);
        chk8(lp.data, 8'hA7);
        // pointer starts below a byte carry on purpose
        p = {seed[15:8], 8'hFE};
        wr(A_PTR_LO, p[7:0]);
        wr(A_PTR_HI, p[15:8]);
        wr(A_CTRL, 8'h01);
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            xfer(seed[0], A_SCHED, seed[15:8]);
            chk16(lcmd.addr, p);
            chk_b(lcmd.wr, seed[0]);
            chk8(seed[0] ? lcmd.data : q, seed[0] ? seed[15:8] : p[7:0] ^ 8'hA5);
            p = p + 16'h0001;
        end
        wr(A_CTRL, 8'h00);
        n0 = nreq;
        rdc(A_SCHED, p[7:0] ^ 8'hA5);
        rdc(A_SCHED, p[7:0] ^ 8'hA5);
        chk16(16'(nreq - n0), 16'h0002);
        wr(A_SWOE, 8'h01);
        bd <= seed[7:0];
        n0 = nreq;
        rdc(A_SCHED, {3'h0, seed[4:0]});
        rdc(A_DIRECT, {3'h0, seed[4:0]});
        wr(A_SWOE, 8'h00);
        busy <= 1'b1;
        wr(A_DIRECT, 8'h3C);
        chk16(16'(nreq - n0), 16'h0000);
        busy <= 1'b0;
        wr(A_DIRECT, 8'hC3);
        chk16(16'(nreq - n0), 16'h0001);
        chk_b(lcmd.direct, 1'b1);
        chk8(lcmd.data, 8'hC3);
        wr(A_IMSK0, 8'hFF);
        wr(A_IMSK1, 8'h0F);
        wr(A_ICTL, 8'h01);
        for (i = 0; i < NUM_SRC; i++) begin
            evt <= 12'h001 << i;
            @(posedge clk);
            evt <= 12'h000;
            rdc(i < 8 ? A_IST0 : A_IST1, 8'h01 << (i % 8));
            chk_b(irq, 1'b1);
            wr(i < 8 ? A_IST0 : A_IST1, 8'h01 << (i % 8));
            chk_b(irq, 1'b0);
        end
        // masked source still polls; open-drain drives enable only
        wr(A_IMSK0, 8'hFE);
        wr(A_ICTL, 8'h03);
        evt <= 12'h003;
        @(posedge clk);
        evt <= 12'h000;
        rdc(A_IST0, 8'h03);
        chk_b(irq_oe, 1'b1);
        chk_b(irq, 1'b0);
        wr(A_IST0, 8'h02);
        chk_b(irq_oe, 1'b0);
        report_and_stop();
    end
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
endmodule

// File: src/lmb_mcu_port.sv
// local microcontroller port: bus cycles, straps, decode, interrupts, buffer ports
// assumes all pins synchronous to ref_clk_in; buffer manager arbitrates buf requests
// Operation
// - separate-strobe mode: write timing comes from active-low write strobe.
// - separate-strobe mode: read timing comes from active-low read strobe.
// - style strap high selects separate strobes; low selects direction plus strobe.
// - direction plus strobe: write line high means read, low means write.
// - direction plus strobe read: drive data only after strobe rises.
// - direction plus strobe write: capture data at strobe falling edge.
// - mux strap sampled high selects multiplexed address/data bus.
// - mux strap sampled low selects separate address and data buses.
// - five low buffer data lines are user switches readable by firmware.
// - answer addresses 40H to FFH only; system reserves that range.
// - PC register file sits at 40H-47H or 60H-67H by base select.
// - PC register file blocked after reset until base is programmed.
// - four interrupt registers hold status and mask per source.
// - interrupt output gated by masks and global enable; open-drain or push-pull.
// - twelve listed interrupt sources feed the status flags.
// - status registers stay readable for polling without interrupts.
// - with output-enable inhibit set, reads of 68H or 70H return switches.
// - scheduled port uses the disk address pointer as buffer address.
// - scheduled port access bumps pointer when auto-increment bit set.
// - scheduled accesses go through the arbiter, interleaved with PC transfers.
// - direct port used only with no disk transfer or correction running.
`timescale 1ns/10ps
module lmb_mcu_port (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe_out,
    input wire logic [7:0] addr_in,
    input wire logic ale_in,
    input wire logic write_ctl_in,
    input wire logic read_or_data_strobe_in,
    input wire logic [7:0] bd_in,
    input wire logic [lmb_pkg::NUM_SRC-1:0] irq_evt_in,
    output logic irq_out,
    output logic irq_oe_out,
    output logic buf_req_out,
    output lmb_pkg::lmb_buf_cmd_t buf_cmd_out,
    input wire logic buf_ack_in,
    input wire logic [7:0] buf_rdata_in,
    input wire logic xfer_busy_in,
    output logic pcr_sel_out,
    output lmb_pkg::lmb_pcr_cmd_t pcr_cmd_out,
    input wire logic [7:0] pcr_rdata_in,
    output logic muxed_mode_out,
    output logic strobe_style_out,
    output logic host_type_out
);
    import lmb_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RD = 4'b0010,
        ST_WR = 4'b0100,
        ST_BUF = 4'b1000
    } lmb_state_t;

    lmb_state_t state;
    lmb_state_t next_state;

    logic strap_done;
    logic dir_mode;
    logic [7:0] addr_lat;
    logic act_q;
    logic rd_cyc;
    logic [7:0] cyc_addr;
    logic [7:0] wdata_q;
    logic [7:0] rd_hold;
    logic [7:0] ctrl;
    logic [15:0] ptr;
    logic swoe;
    logic base_sel;
    logic base_set;
    logic [NUM_SRC-1:0] ist;
    logic [NUM_SRC-1:0] imsk;
    logic [1:0] ictl;

    // mode decode: read strobe is active low in separate mode, high as data strobe
    wire sep_rd = ~dir_mode & ~read_or_data_strobe_in;
    wire sep_wr = ~dir_mode & ~write_ctl_in;
    wire dir_act = dir_mode & read_or_data_strobe_in;
    wire act = sep_rd | sep_wr | dir_act;
    wire is_rd = dir_mode ? write_ctl_in : sep_rd;
    // no cycle starts before straps settle or while a buffer request is pending
    wire start = act & ~act_q & strap_done & (state == ST_IDLE);
    wire stop = ~act & act_q;
    wire [7:0] cur_addr = muxed_mode_out ? addr_lat : addr_in;
    wire in_range = |cur_addr[7:6];
    wire [4:0] pcr_base = base_sel ? PCR_BASE_HI : PCR_BASE_LO;
    wire pcr_hit = base_set && (cyc_addr[7:3] == pcr_base);
    wire pcr_hit_now = base_set && (cur_addr[7:3] == pcr_base);
    wire sched_hit = cur_addr == A_SCHED;
    wire direct_hit = cur_addr == A_DIRECT;
    wire direct_ok = ~xfer_busy_in;
    // inhibit turns buffer reads into switch reads
    wire buf_rd_go = start && is_rd && in_range && !swoe
        && (sched_hit || (direct_hit && direct_ok));
    wire wr_done = (state == ST_WR) && stop;
    wire w_sched = wr_done && cyc_addr == A_SCHED;
    wire w_direct = wr_done && cyc_addr == A_DIRECT && direct_ok;
    wire buf_wr_go = w_sched || w_direct;
    wire buf_done = (state == ST_BUF) && buf_ack_in;
    wire ptr_bump = ctrl[AUTOINC_BIT] && (
        (start && is_rd && in_range && sched_hit) || w_sched);
    wire any_irq = |(ist & imsk) & ictl[GEN_BIT];
    wire [7:0] sw_val = {3'b000, bd_in[4:0]};
    wire wr_ist0 = wr_done && cyc_addr == A_IST0;
    wire wr_ist1 = wr_done && cyc_addr == A_IST1;
    wire [NUM_SRC-1:0] ist_clr = {wr_ist1 ? wdata_q[3:0] : 4'h0,
        wr_ist0 ? wdata_q : 8'h00};

    logic [7:0] reg_rd;
    always_comb begin
        case (cur_addr)
            A_CTRL: reg_rd = ctrl;
            A_PTR_LO: reg_rd = ptr[7:0];
            A_PTR_HI: reg_rd = ptr[15:8];
            A_SWOE: reg_rd = {7'h00, swoe};
            A_BASE: reg_rd = {base_set, 6'h00, base_sel};
            A_IST0: reg_rd = ist[7:0];
            A_IST1: reg_rd = {4'h0, ist[11:8]};
            A_IMSK0: reg_rd = imsk[7:0];
            A_IMSK1: reg_rd = {4'h0, imsk[11:8]};
            A_ICTL: reg_rd = {6'h00, ictl};
            A_STRAP: reg_rd = {muxed_mode_out, strobe_style_out, host_type_out, 5'h00};
            A_SCHED: reg_rd = sw_val;
            A_DIRECT: reg_rd = sw_val;
            default: reg_rd = pcr_hit_now ? pcr_rdata_in : REG_RST;
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (buf_rd_go) begin
                    next_state = ST_BUF;
                end else if (start && in_range) begin
                    next_state = is_rd ? ST_RD : ST_WR;
                end
            end
            ST_RD: begin
                if (stop) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WR: begin
                if (stop) begin
                    next_state = buf_wr_go ? ST_BUF : ST_IDLE;
                end
            end
            ST_BUF: begin
                if (buf_ack_in) begin
                    next_state = buf_cmd_out.wr ? ST_IDLE : ST_RD;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            strap_done <= 1'b0;
            dir_mode <= 1'b0;
            muxed_mode_out <= 1'b0;
            strobe_style_out <= 1'b0;
            host_type_out <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            dir_mode <= ~bd_in[STYLE_STRAP_BIT];
            muxed_mode_out <= bd_in[MUX_STRAP_BIT];
            strobe_style_out <= bd_in[STYLE_STRAP_BIT];
            host_type_out <= bd_in[HOST_STRAP_BIT];
        end
    end

    // write data follows the bus while the strobe is active so the edge value is kept
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            state <= ST_IDLE;
            act_q <= 1'b0;
            addr_lat <= REG_RST;
            cyc_addr <= REG_RST;
            wdata_q <= REG_RST;
            rd_cyc <= 1'b0;
        end else begin
            state <= next_state;
            act_q <= act & strap_done;
            if (ale_in) begin
                addr_lat <= ad_in;
            end
            if (start) begin
                cyc_addr <= cur_addr;
                rd_cyc <= is_rd;
            end
            if (act) begin
                wdata_q <= ad_in;
            end
        end
    end

    // register read data is captured at strobe start, buffer read data at grant, so output stays stable through the cycle
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            rd_hold <= REG_RST;
            ad_out <= REG_RST;
            ad_oe_out <= 1'b0;
        end else begin
            if (start && is_rd) begin
                rd_hold <= reg_rd;
            end else if (buf_done && !buf_cmd_out.wr) begin
                rd_hold <= buf_rdata_in;
            end
            ad_out <= rd_hold;
            ad_oe_out <= (state == ST_RD) && act && rd_cyc;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ctrl <= REG_RST;
            ptr <= PTR_RST;
            swoe <= 1'b0;
            base_sel <= 1'b0;
            base_set <= 1'b0;
            imsk <= SRC_RST;
            ictl <= 2'b00;
        end else begin
            if (ptr_bump) begin
                ptr <= ptr + 16'h0001;
            end
            if (wr_done) begin
                case (cyc_addr)
                    A_CTRL: ctrl <= wdata_q;
                    A_PTR_LO: ptr[7:0] <= wdata_q;
                    A_PTR_HI: ptr[15:8] <= wdata_q;
                    A_SWOE: swoe <= wdata_q[INHIBIT_BIT];
                    A_BASE: begin
                        base_sel <= wdata_q[BASE_SEL_BIT];
                        base_set <= 1'b1;
                    end
                    A_IMSK0: imsk[7:0] <= wdata_q;
                    A_IMSK1: imsk[11:8] <= wdata_q[3:0];
                    A_ICTL: ictl <= wdata_q[1:0];
                    default: ;
                endcase
            end
        end
    end

    // twelve sources set flags
    // a new event wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ist <= SRC_RST;
        end else begin
            ist <= (ist & ~ist_clr) | irq_evt_in;
        end
    end

    // open-drain pulls low, push-pull drives level
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
            irq_oe_out <= 1'b0;
        end else begin
            irq_out <= ictl[ODRAIN_BIT] ? 1'b0 : any_irq;
            irq_oe_out <= ictl[ODRAIN_BIT] ? any_irq : 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            buf_req_out <= 1'b0;
            buf_cmd_out <= '0;
        end else if (buf_rd_go || buf_wr_go) begin
            buf_req_out <= 1'b1;
            buf_cmd_out.wr <= buf_wr_go;
            buf_cmd_out.direct <= buf_wr_go ? w_direct : direct_hit;
            buf_cmd_out.addr <= ptr;
            buf_cmd_out.data <= wdata_q;
        end else if (buf_done) begin
            buf_req_out <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            pcr_sel_out <= 1'b0;
            pcr_cmd_out <= '0;
        end else begin
            pcr_sel_out <= (start && in_range && pcr_hit_now && is_rd)
                || (wr_done && pcr_hit);
            pcr_cmd_out.addr <= start ? cur_addr[2:0] : cyc_addr[2:0];
            pcr_cmd_out.wr <= wr_done;
            pcr_cmd_out.data <= wdata_q;
        end
    end
endmodule

// File: src/lmb_pkg.sv
// shared constants and types for the local microcontroller port
// assumes one 250 MHz clock and byte-wide registers at 40H to FFH
package lmb_pkg;
    localparam logic [7:0] A_CTRL = 8'h48;
    localparam logic [7:0] A_PTR_LO = 8'h49;
    localparam logic [7:0] A_PTR_HI = 8'h4A;
    localparam logic [7:0] A_SWOE = 8'h52;
    localparam logic [7:0] A_BASE = 8'h53;
    localparam logic [7:0] A_IST0 = 8'h54;
    localparam logic [7:0] A_IST1 = 8'h55;
    localparam logic [7:0] A_IMSK0 = 8'h56;
    localparam logic [7:0] A_IMSK1 = 8'h57;
    localparam logic [7:0] A_ICTL = 8'h58;
    localparam logic [7:0] A_STRAP = 8'h5A;
    localparam logic [7:0] A_SCHED = 8'h68;
    localparam logic [7:0] A_DIRECT = 8'h70;
    localparam logic [4:0] PCR_BASE_LO = 5'h08;
    localparam logic [4:0] PCR_BASE_HI = 5'h0C;
    localparam int AUTOINC_BIT = 0;
    localparam int INHIBIT_BIT = 0;
    localparam int BASE_SEL_BIT = 0;
    localparam int GEN_BIT = 0;
    localparam int ODRAIN_BIT = 1;
    localparam int MUX_STRAP_BIT = 7;
    localparam int STYLE_STRAP_BIT = 6;
    localparam int HOST_STRAP_BIT = 5;
    localparam int NUM_SRC = 12;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [NUM_SRC-1:0] SRC_RST = 12'h000;

    typedef struct packed {
        logic wr;
        logic direct;
        logic [15:0] addr;
        logic [7:0] data;
    } lmb_buf_cmd_t;

    typedef struct packed {
        logic [2:0] addr;
        logic wr;
        logic [7:0] data;
    } lmb_pcr_cmd_t;
endpackage
